// [verilog/radio_config_register_bank.sv]
`timescale 1ns/10ps

module radio_config_register_bank
  import radio_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [radio_cfg_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [radio_cfg_pkg::DATA_W-1:0] i_pwdata,
  output logic [radio_cfg_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_bit_tick,
  output logic [radio_cfg_pkg::BR_DIV_W-1:0] o_bit_rate_divider,
  output logic [radio_cfg_pkg::REG_W-1:0] o_onoff_floor_level,
  output logic [radio_cfg_pkg::FIFO_DEPTH_W-1:0] o_fifo_depth_code,
  output logic [radio_cfg_pkg::FIFO_BYTES_W-1:0] o_fifo_depth_bytes,
  output logic [radio_cfg_pkg::FIFO_LEVEL_W-1:0] o_fifo_level_threshold,
  output logic o_divider_bank_select,
  output logic [radio_cfg_pkg::REG_W-1:0] o_ref_divider,
  output logic [radio_cfg_pkg::REG_W-1:0] o_main_divider,
  output logic [radio_cfg_pkg::REG_W-1:0] o_swallow_divider
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [IDX_W-1:0] idx);
    byte_addr = {idx, WORD_ALIGN};
  endfunction

  function automatic logic [DATA_W-1:0] zext(input logic [REG_W-1:0] value);
    zext = {{(DATA_W - REG_W){1'b0}}, value};
  endfunction

  // Depth codes step in units of sixteen bytes, so the byte count is a
  // product of the code rather than a lookup table.
  function automatic logic [FIFO_BYTES_W-1:0] depth_bytes(
    input logic [FIFO_DEPTH_W-1:0] code
  );
    depth_bytes = FIFO_BYTES_W'((int'(code) + 1) * FIFO_DEPTH_STEP);
  endfunction

  cfg_state_t state_reg;
  cfg_state_t state_next;
  logic bit_tick;
  logic setup_phase;
  logic access_write;
  logic addr_hit;
  logic [DATA_W-1:0] read_value;
  logic [DATA_W-1:0] status_value;
  logic [REG_W-1:0] wbyte;
  logic [FIFO_DEPTH_W-1:0] wr_depth;
  logic [FIFO_LEVEL_W-1:0] wr_level;
  logic wr_select;
  logic [2:0][REG_W-1:0] active_bank;

  // ----------------------------------------------------------------------
  // Bit-rate tick generator
  // ----------------------------------------------------------------------
  // The divider field is passed live: a lower value at or below the count reached
  // ends the bit in progress at the next prescaler wrap, a higher one stretches it.
  bit_rate_tick u_bit_rate_tick
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_divider(state_reg.bit_rate[BR_DIV_LSB +: BR_DIV_W]),
    .o_tick(bit_tick)
  );

  // ----------------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------------
  // Read data is captured in the setup cycle so that it leaves a flip-flop;
  // this lets the slave answer in the first access cycle with no wait.
  assign setup_phase = i_psel && !i_penable;
  assign access_write = i_psel && i_penable && i_pwrite;
  assign wbyte = i_pwdata[REG_W-1:0];

  // ----------------------------------------------------------------------
  // Write data fields
  // ----------------------------------------------------------------------
  // Only the low byte of the bus word is stored, so software may write a
  // whole word; the upper bits are dropped without raising an error.
  assign wr_depth = wbyte[FIFO_DEPTH_LSB +: FIFO_DEPTH_W];
  assign wr_level = wbyte[FIFO_LEVEL_LSB +: FIFO_LEVEL_W];
  assign wr_select = i_pwdata[BANK_SEL_BIT];

  // ----------------------------------------------------------------------
  // Status word and read mux
  // ----------------------------------------------------------------------
  // The tick count wraps without notice; software that reads it twice must
  // allow for at most one wrap between the two reads.
  always_comb
  begin
    status_value = '0;
    status_value[STAT_BANK_BIT] = state_reg.bank_select;
    status_value[STAT_COUNT_LSB +: TICK_COUNT_W] = state_reg.tick_count;
  end

  always_comb
  begin
    addr_hit = 1'b1;
    read_value = '0;
    unique case (i_paddr)
      byte_addr(IDX_BIT_RATE_DIVIDER):
      begin
        read_value = zext(state_reg.bit_rate);
      end
      byte_addr(IDX_OOK_FLOOR_LEVEL):
      begin
        read_value = zext(state_reg.floor_level);
      end
      byte_addr(IDX_FIFO_DEPTH_AND_LEVEL):
      begin
        read_value = zext({state_reg.fifo_depth, state_reg.fifo_level});
      end
      byte_addr(IDX_SYNTH_REF_DIV_A):
      begin
        read_value = zext(state_reg.bank_a[0]);
      end
      byte_addr(IDX_SYNTH_MAIN_DIV_A):
      begin
        read_value = zext(state_reg.bank_a[1]);
      end
      byte_addr(IDX_SYNTH_SWALLOW_DIV_A):
      begin
        read_value = zext(state_reg.bank_a[2]);
      end
      byte_addr(IDX_SYNTH_REF_DIV_B):
      begin
        read_value = zext(state_reg.bank_b[0]);
      end
      byte_addr(IDX_SYNTH_MAIN_DIV_B):
      begin
        read_value = zext(state_reg.bank_b[1]);
      end
      byte_addr(IDX_SYNTH_SWALLOW_DIV_B):
      begin
        read_value = zext(state_reg.bank_b[2]);
      end
      byte_addr(IDX_BANK_CONTROL):
      begin
        read_value[BANK_SEL_BIT] = state_reg.bank_select;
      end
      byte_addr(IDX_BLOCK_STATUS):
      begin
        read_value = status_value;
      end
      default:
      begin
        // Unmapped and misaligned addresses land here: they read zero and
        // raise pslverr in the access phase.
        addr_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    // The tick count advances during bus accesses too; a status read samples
    // it in the setup cycle, so a tick in the access cycle shows next time.
    if (bit_tick)
    begin
      state_next.tick_count = state_reg.tick_count + 1'b1;
    end
    if (setup_phase)
    begin
      // Reads only sample; nothing is cleared or advanced by them.
      state_next.rdata = i_pwrite ? '0 : read_value;
      state_next.slverr = !addr_hit;
    end
    if (access_write)
    begin
      unique case (i_paddr)
        byte_addr(IDX_BIT_RATE_DIVIDER):
        begin
          // The reserved top bit is stored too, so it reads back as written.
          state_next.bit_rate = wbyte;
        end
        byte_addr(IDX_OOK_FLOOR_LEVEL):
        begin
          state_next.floor_level = wbyte;
        end
        byte_addr(IDX_FIFO_DEPTH_AND_LEVEL):
        begin
          state_next.fifo_depth = wr_depth;
          state_next.fifo_level = wr_level;
        end
        byte_addr(IDX_SYNTH_REF_DIV_A):
        begin
          state_next.bank_a[0] = wbyte;
        end
        byte_addr(IDX_SYNTH_MAIN_DIV_A):
        begin
          state_next.bank_a[1] = wbyte;
        end
        byte_addr(IDX_SYNTH_SWALLOW_DIV_A):
        begin
          state_next.bank_a[2] = wbyte;
        end
        byte_addr(IDX_SYNTH_REF_DIV_B):
        begin
          state_next.bank_b[0] = wbyte;
        end
        byte_addr(IDX_SYNTH_MAIN_DIV_B):
        begin
          state_next.bank_b[1] = wbyte;
        end
        byte_addr(IDX_SYNTH_SWALLOW_DIV_B):
        begin
          state_next.bank_b[2] = wbyte;
        end
        byte_addr(IDX_BANK_CONTROL):
        begin
          // Only bit 0 is kept; the rest of the control word reads back as zero.
          state_next.bank_select = wr_select;
        end
        default:
        begin
          state_next.bank_select = state_reg.bank_select;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Every register shares one asynchronous reset, so a reset at any time
  // restores both divider banks and hands the synthesizer back to bank A.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= CFG_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------------
  // The slave never inserts wait states, so every access completes in its
  // first access cycle; pslverr carries meaning only in that cycle.
  assign o_prdata = state_reg.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && state_reg.slverr;

  // ----------------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------------
  assign o_bit_tick = bit_tick;
  assign o_bit_rate_divider = state_reg.bit_rate[BR_DIV_LSB +: BR_DIV_W];
  assign o_onoff_floor_level = state_reg.floor_level;
  assign o_fifo_depth_code = state_reg.fifo_depth;
  assign o_fifo_depth_bytes = depth_bytes(state_reg.fifo_depth);
  assign o_fifo_level_threshold = state_reg.fifo_level;
  assign o_divider_bank_select = state_reg.bank_select;

  // ----------------------------------------------------------------------
  // Divider bank routing
  // ----------------------------------------------------------------------
  // The switch is glitch-free at the register level only; the synthesizer
  // must tolerate a new divider set arriving at an arbitrary clock edge.
  always_comb
  begin
    if (state_reg.bank_select)
    begin
      active_bank = state_reg.bank_b;
    end
    else
    begin
      active_bank = state_reg.bank_a;
    end
  end

  assign o_ref_divider = active_bank[0];
  assign o_main_divider = active_bank[1];
  assign o_swallow_divider = active_bank[2];

endmodule

// [verilog/radio_cfg_pkg.sv]
package radio_cfg_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_W = 6;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_BIT_RATE_DIVIDER = 6'h03;
  localparam logic [IDX_W-1:0] IDX_OOK_FLOOR_LEVEL = 6'h04;
  localparam logic [IDX_W-1:0] IDX_FIFO_DEPTH_AND_LEVEL = 6'h05;
  localparam logic [IDX_W-1:0] IDX_SYNTH_REF_DIV_A = 6'h06;
  localparam logic [IDX_W-1:0] IDX_SYNTH_MAIN_DIV_A = 6'h07;
  localparam logic [IDX_W-1:0] IDX_SYNTH_SWALLOW_DIV_A = 6'h08;
  localparam logic [IDX_W-1:0] IDX_SYNTH_REF_DIV_B = 6'h09;
  localparam logic [IDX_W-1:0] IDX_SYNTH_MAIN_DIV_B = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_SYNTH_SWALLOW_DIV_B = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_BANK_CONTROL = 6'h10;
  localparam logic [IDX_W-1:0] IDX_BLOCK_STATUS = 6'h11;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_BIT_RATE_DIVIDER = 8'h0F;
  localparam logic [REG_W-1:0] RST_OOK_FLOOR_LEVEL = 8'h0C;
  localparam logic [1:0] RST_FIFO_DEPTH = 2'h0;
  localparam logic [5:0] RST_FIFO_LEVEL = 6'h0F;
  localparam logic [REG_W-1:0] RST_REF_DIV_A = 8'h77;
  localparam logic [REG_W-1:0] RST_MAIN_DIV_A = 8'h64;
  localparam logic [REG_W-1:0] RST_SWALLOW_DIV_A = 8'h32;
  localparam logic [REG_W-1:0] RST_REF_DIV_B = 8'h74;
  localparam logic [REG_W-1:0] RST_MAIN_DIV_B = 8'h62;
  localparam logic [REG_W-1:0] RST_SWALLOW_DIV_B = 8'h32;
  localparam logic RST_BANK_SELECT = 1'b0;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BR_DIV_LSB = 0;
  localparam int BR_DIV_W = 7;
  localparam int BR_RES_BIT = 7;
  localparam int FIFO_LEVEL_LSB = 0;
  localparam int FIFO_LEVEL_W = 6;
  localparam int FIFO_DEPTH_LSB = 6;
  localparam int FIFO_DEPTH_W = 2;
  localparam int BANK_SEL_BIT = 0;
  localparam int STAT_BANK_BIT = 0;
  localparam int STAT_COUNT_LSB = 8;
  localparam int TICK_COUNT_W = 8;

  // ----------------------------------------------------------------------
  // Bit-rate timing: crystal divided by 64 times (divider plus one)
  // ----------------------------------------------------------------------
  localparam int XTAL_HZ = 100_000_000;
  localparam int BIT_PRESCALE = 64;
  localparam logic [5:0] PRESCALE_LAST = 6'(BIT_PRESCALE - 1);
  localparam int FIFO_DEPTH_STEP = 16;
  localparam int FIFO_BYTES_W = 7;

  // ----------------------------------------------------------------------
  // State of the register bank
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [REG_W-1:0] bit_rate;
    logic [REG_W-1:0] floor_level;
    logic [FIFO_DEPTH_W-1:0] fifo_depth;
    logic [FIFO_LEVEL_W-1:0] fifo_level;
    logic [2:0][REG_W-1:0] bank_a;
    logic [2:0][REG_W-1:0] bank_b;
    logic bank_select;
    logic [TICK_COUNT_W-1:0] tick_count;
    logic [DATA_W-1:0] rdata;
    logic slverr;
  } cfg_state_t;

  localparam cfg_state_t CFG_RESET = '{
    bit_rate: RST_BIT_RATE_DIVIDER,
    floor_level: RST_OOK_FLOOR_LEVEL,
    fifo_depth: RST_FIFO_DEPTH,
    fifo_level: RST_FIFO_LEVEL,
    bank_a: {RST_SWALLOW_DIV_A, RST_MAIN_DIV_A, RST_REF_DIV_A},
    bank_b: {RST_SWALLOW_DIV_B, RST_MAIN_DIV_B, RST_REF_DIV_B},
    bank_select: RST_BANK_SELECT,
    tick_count: '0,
    rdata: '0,
    slverr: 1'b0
  };

  typedef struct packed {
    logic [5:0] prescale;
    logic [BR_DIV_W-1:0] count;
    logic tick;
  } tick_state_t;

  localparam tick_state_t TICK_RESET = '{prescale: '0, count: '0, tick: 1'b0};

endpackage

// [verilog/bit_rate_tick.sv]
`timescale 1ns/10ps

module bit_rate_tick
  import radio_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [radio_cfg_pkg::BR_DIV_W-1:0] i_divider,
  output logic o_tick
);

  tick_state_t state_reg;
  tick_state_t state_next;

  // ----------------------------------------------------------------------
  // One tick every 64 times (divider plus one) clocks
  // ----------------------------------------------------------------------
  // The count compares with >= so that lowering the divider mid-period to or below the count
  // ends the period at the next prescaler wrap instead of wrapping through all 128 values.
  always_comb
  begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.prescale == PRESCALE_LAST)
    begin
      state_next.prescale = '0;
      if (state_reg.count >= i_divider)
      begin
        state_next.count = '0;
        state_next.tick = 1'b1;
      end
      else
      begin
        state_next.count = state_reg.count + 1'b1;
      end
    end
    else
    begin
      state_next.prescale = state_reg.prescale + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= TICK_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_tick = state_reg.tick;

endmodule

// [testbench/radio_cfg_chk.sv]
`timescale 1ns/10ps

// ----
// Port checker; the tick gap counter saturates so a stalled tick stays visible.
// ----
module radio_cfg_chk
  import radio_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [radio_cfg_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [radio_cfg_pkg::DATA_W-1:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_bit_tick,
  input wire logic [radio_cfg_pkg::BR_DIV_W-1:0] o_bit_rate_divider,
  input wire logic [radio_cfg_pkg::REG_W-1:0] o_onoff_floor_level,
  input wire logic [radio_cfg_pkg::FIFO_DEPTH_W-1:0] o_fifo_depth_code,
  input wire logic [radio_cfg_pkg::FIFO_BYTES_W-1:0] o_fifo_depth_bytes,
  input wire logic [radio_cfg_pkg::FIFO_LEVEL_W-1:0] o_fifo_level_threshold,
  input wire logic o_divider_bank_select,
  input wire logic [radio_cfg_pkg::REG_W-1:0] o_ref_divider
);
  logic [13:0] gap_reg;
  logic [13:0] gap_next;

  always_comb
  begin
    gap_next = o_bit_tick ? 14'h0000 : gap_reg + {13'h0000, gap_reg != 14'h3FFF};
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      gap_reg <= 14'h0000;
    else
      gap_reg <= gap_next;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_wr(logic [7:0] a);
    i_psel && i_penable && i_pwrite && i_paddr == a;
  endsequence

  property p_ready; i_psel && i_penable |-> o_pready; endproperty
  property p_err_bad; i_psel && i_penable && i_paddr[1:0] != 2'h0 |-> o_pslverr; endproperty
  property p_err_ok; i_psel && i_penable && i_paddr == 8'h0C |-> !o_pslverr; endproperty
  property p_rst_val;
    $fell(i_rst) |-> o_bit_rate_divider == 7'h0F && o_onoff_floor_level == 8'h0C;
  endproperty
  property p_br; s_wr(8'h0C) |=> o_bit_rate_divider == $past(i_pwdata[6:0]); endproperty
  property p_floor; s_wr(8'h10) |=> o_onoff_floor_level == $past(i_pwdata[7:0]); endproperty
  property p_fifo;
    s_wr(8'h14) |=> {o_fifo_depth_code, o_fifo_level_threshold} == $past(i_pwdata[7:0]);
  endproperty
  property p_bytes; o_fifo_depth_bytes == {o_fifo_depth_code, 4'h0} + 7'h10; endproperty
  property p_sel; s_wr(8'h40) |=> o_divider_bank_select == $past(i_pwdata[0]); endproperty
  property p_bank_a;
    s_wr(8'h18) ##0 !o_divider_bank_select |=> o_ref_divider == $past(i_pwdata[7:0]);
  endproperty
  property p_gap_min; o_bit_tick |-> gap_reg >= 14'h003C; endproperty
  property p_gap_max; gap_reg <= 14'h2008; endproperty

  a_ready: assert property (p_ready) else $error("pready low in access phase");
  a_err_bad: assert property (p_err_bad) else $error("misaligned access not refused");
  a_err_ok: assert property (p_err_ok) else $error("mapped access refused");
  a_rst_val: assert property (p_rst_val) else $error("wrong value after reset");
  a_br: assert property (p_br) else $error("divider output not updated");
  a_floor: assert property (p_floor) else $error("floor output not updated");
  a_fifo: assert property (p_fifo) else $error("fifo fields not updated");
  a_bytes: assert property (p_bytes) else $error("fifo byte count wrong");
  a_sel: assert property (p_sel) else $error("bank select not updated");
  a_bank_a: assert property (p_bank_a) else $error("bank A not routed");
  a_gap_min: assert property (p_gap_min) else $error("bit tick too early");
  a_gap_max: assert property (p_gap_max) else $error("bit tick missing");
endmodule

bind radio_config_register_bank radio_cfg_chk u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_bit_tick(o_bit_tick),
  .o_bit_rate_divider(o_bit_rate_divider), .o_onoff_floor_level(o_onoff_floor_level),
  .o_fifo_depth_code(o_fifo_depth_code), .o_fifo_depth_bytes(o_fifo_depth_bytes),
  .o_fifo_level_threshold(o_fifo_level_threshold),
  .o_divider_bank_select(o_divider_bank_select), .o_ref_divider(o_ref_divider));

// [testbench/tb_radio_config_register_bank.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin check_count++; if ((ac) !== (ex)) begin bad_count++; $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, ac); end end

module tb_radio_config_register_bank;
  import radio_cfg_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, tick, sel, erv;
  logic [7:0] paddr, floor, ref_d, main_d, swal_d, d8, ntick, snap;
  logic [31:0] pwdata, prdata, rdv;
  logic [6:0] br, bytes;
  logic [1:0] dcode;
  logic [5:0] lvl;
  logic [15:0] seed;
  logic [7:0] shadow [9];
  logic [7:0] addrs [9] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  logic [7:0] rstv [9] = '{8'h0F, 8'h0C, 8'h0F, 8'h77, 8'h64, 8'h32, 8'h74, 8'h62, 8'h32};
  int bad_count = 0;
  int check_count = 0;
  int per;

  radio_config_register_bank dut (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_bit_tick(tick),
    .o_bit_rate_divider(br), .o_onoff_floor_level(floor), .o_fifo_depth_code(dcode),
    .o_fifo_depth_bytes(bytes), .o_fifo_level_threshold(lvl), .o_divider_bank_select(sel),
    .o_ref_divider(ref_d), .o_main_divider(main_d), .o_swallow_divider(swal_d));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [6:0] exp_bytes(input logic [1:0] c);
    return 7'({c, 4'h0}) + 7'h10;
  endfunction

  // Reference count of bit ticks, taken at the same edges as the status word.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      ntick <= 8'h00;
    else if (tick)
      ntick <= ntick + 8'h01;
  end

  // ----
  // Bus and measurement tasks
  // ----
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    snap = ntick;
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask

  task automatic measure();
    int n;
    n = 0;
    do @(posedge clk); while (tick !== 1'b1 && ++n < 9000);
    per = 0;
    do @(posedge clk); while (tick !== 1'b1 && ++per < 9000);
    per++;
  endtask

  task automatic check_outs(input int b);
    `CHK("divider", shadow[0][6:0], br)
    `CHK("floor", shadow[1], floor)
    `CHK("fifo", shadow[2], {dcode, lvl})
    `CHK("bytes", exp_bytes(shadow[2][7:6]), bytes)
    `CHK("bank", {shadow[b], shadow[b+1], shadow[b+2]}, {ref_d, main_d, swal_d})
    `CHK("select out", b == 6, sel)
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #500000;
    bad_count++;
    complete_run;
  end

  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    seed = 16'hFEAA;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    shadow = rstv;
    check_outs(3);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, addrs[i], 32'h0);
      `CHK("reset read", {24'h0, rstv[i]}, rdv)
    end
    measure();
    `CHK("reset tick period", 1024, per)
    $display("test reset values done");
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 9; i++)
      begin
        seed = lfsr(seed);
        d8 = seed[7:0];
        if (i == 2)
          d8[7:6] = k[1:0];
        shadow[i] = d8;
        apb(1'b1, addrs[i], {seed[15:8], 16'hA5C3, d8});
        apb(1'b0, addrs[i], 32'h0);
        `CHK("readback", {24'h0, d8}, rdv)
        check_outs(3);
      end
    $display("test random read write done");
    apb(1'b1, 8'h40, 32'h1);
    check_outs(6);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("select read", 32'h1, rdv)
    apb(1'b0, 8'h44, 32'h0);
    `CHK("status", {16'h0, snap, 7'h0, 1'b1}, rdv)
    apb(1'b1, 8'h44, 32'hFFFF);
    `CHK("status write error", 1'b0, erv)
    check_outs(6);
    apb(1'b1, 8'h40, 32'h0);
    check_outs(3);
    $display("test bank select done");
    apb(1'b1, 8'h0D, 32'hFF);
    `CHK("misaligned error", 1'b1, erv)
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped data", 32'h0, rdv)
    `CHK("unmapped error", 1'b1, erv)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("mapped error", 1'b0, erv)
    `CHK("no side effect", {24'h0, shadow[0]}, rdv)
    $display("test refused access done");
    for (int c = 0; c < 3; c++)
    begin
      seed = lfsr(seed);
      d8 = (c == 0) ? 8'h80 : {5'h00, seed[2:0]};
      apb(1'b1, 8'h0C, {24'h0, d8});
      measure();
      `CHK("tick period", 64 * (d8[6:0] + 1), per)
    end
    $display("test bit rate done");
    complete_run;
  end
endmodule
